// file: rtl/rdgec_defines.svh
// Constant definitions for the differential driver gate and echo control block.
`ifndef RDGEC_DEFINES_SVH
`define RDGEC_DEFINES_SVH
`define RDGEC_ECHO_ADDR 9'h1C2
`define RDGEC_ECHO_RESET 16'h0000
`define RDGEC_ECHO_BIT 0
`define RDGEC_CLK_HZ 50000000
`define RDGEC_LEAD_CHARS 2
`define RDGEC_BITS_PER_CHAR 10
`define RDGEC_SLOW_HOLD_MS 3
`define RDGEC_SLOW_HOLD_CYC ((`RDGEC_CLK_HZ / 1000) * `RDGEC_SLOW_HOLD_MS)
`define RDGEC_RATE_50 3'h0
`define RDGEC_RATE_300 3'h1
`define RDGEC_RATE_600 3'h2
`define RDGEC_RATE_1200 3'h3
`define RDGEC_RATE_2400 3'h4
`define RDGEC_RATE_4800 3'h5
`define RDGEC_RATE_9600 3'h6
`define RDGEC_RATE_19200 3'h7
`define RDGEC_FIFO_DEPTH 8
`endif

// file: rtl/rdgec_pkg.sv
// Types shared by the driver gate and echo control block.
package rdgec_pkg;
    typedef enum logic [4:0] {
        RDGEC_IDLE = 5'h01,
        RDGEC_LEAD = 5'h02,
        RDGEC_SEND = 5'h04,
        RDGEC_HOLD = 5'h08,
        RDGEC_NEXT = 5'h10
    } rdgec_state_t;
endpackage

// file: rtl/rdgec_fifo_if.sv
// Stream carrier between the block top and its transmit FIFO.
`timescale 1ns/100ps
`default_nettype none
interface rdgec_fifo_if;
    logic in_valid;
    logic in_ready;
    logic [7:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [7:0] out_data;
    modport fifo (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
    modport user (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
endinterface
`default_nettype wire

// file: rtl/rdgec_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module rdgec_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Stream
    rdgec_fifo_if.fifo s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign s.in_ready = (count != DEPTH[AW:0]);
    assign s.out_valid = (count != '0);
    assign s.out_data = mem[rd_ptr];
    assign push = s.in_valid && s.in_ready;
    assign pop = s.out_valid && s.out_ready;

    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push)
        begin
            mem[wr_ptr] <= s.in_data[WIDTH-1:0];
        end
    end
endmodule
`default_nettype wire

// file: rtl/rdgec_top.sv
// Transmit driver gate, lead mark, hold time and echo control for the differential channel.
// ==========================================================================
// Functional notes
// - Pair driven while output enable is high, floated while it is low.
// - After gate opens, hold mark two character times before first data.
// - At 600 bps and faster, gate closes within one bit after last bit.
// - At 50 or 300 bps, gate may stay open several milliseconds after.
// - Echo setting 0 on two-wire: own characters delivered as received data.
// - Echo setting 1: characters caused by own transmission are discarded.
// - Echo setting word at address 1C2H, host writable, reads zero after reset.
// - Echo setting sampled only between transmissions; changes while sending ignored.
// - Echo suppression only on the second channel in two-wire half-duplex mode.
`timescale 1ns/100ps
`default_nettype none
`include "rdgec_defines.svh"
module rdgec_top
    import rdgec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Buffer word access
    input wire logic buf_wr,
    input wire logic buf_rd,
    input wire logic [8:0] buf_addr,
    input wire logic [15:0] buf_wdata,
    output logic [15:0] buf_rdata,
    // Channel configuration
    input wire logic [2:0] baud_sel,
    input wire logic two_wire,
    input wire logic second_channel,
    // Transmit characters
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Characters from the receiver
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    output logic rx_out_valid,
    output logic [7:0] rx_out_data,
    // Transmit pair
    output logic tx_pair_pos,
    output logic tx_pair_neg,
    output logic tx_pair_oe,
    output logic tx_busy
);
    // ======================================================================
    // Bit timing
    logic [3:0] bit_idx, next_bit_idx;
    logic [21:0] tick_cnt, next_tick_cnt;
    logic [21:0] bit_cycles;
    logic [7:0] shreg, next_shreg;
    logic [15:0] echo_word, next_echo_word;
    logic echo_drop, next_echo_drop;
    logic [1:0] lead_cnt, next_lead_cnt;
    rdgec_state_t state, next_state;
    rdgec_fifo_if fq();

    function automatic logic [21:0] rate_cycles(input logic [2:0] sel);
        case (sel)
            `RDGEC_RATE_50: rate_cycles = 22'(`RDGEC_CLK_HZ / 50);
            `RDGEC_RATE_300: rate_cycles = 22'(`RDGEC_CLK_HZ / 300);
            `RDGEC_RATE_600: rate_cycles = 22'(`RDGEC_CLK_HZ / 600);
            `RDGEC_RATE_1200: rate_cycles = 22'(`RDGEC_CLK_HZ / 1200);
            `RDGEC_RATE_2400: rate_cycles = 22'(`RDGEC_CLK_HZ / 2400);
            `RDGEC_RATE_4800: rate_cycles = 22'(`RDGEC_CLK_HZ / 4800);
            `RDGEC_RATE_9600: rate_cycles = 22'(`RDGEC_CLK_HZ / 9600);
            default: rate_cycles = 22'(`RDGEC_CLK_HZ / 19200);
        endcase
    endfunction

    assign bit_cycles = rate_cycles(baud_sel);

    // The queue lets the host run ahead of a slow line; its fullness stalls tx_ready.
    rdgec_fifo #(.WIDTH(8), .DEPTH(`RDGEC_FIFO_DEPTH)) u_fifo
    (
        .clk(clk),
        .reset(reset),
        .s(fq.fifo)
    );
    assign fq.in_valid = tx_valid;
    assign fq.in_data = tx_data;
    assign fq.out_ready = (state == RDGEC_SEND) && (bit_idx == 4'h0) && (tick_cnt == 22'h0);

    // ======================================================================
    // Transmit sequencer
    logic tick_done;
    assign tick_done = (tick_cnt == bit_cycles - 22'h1);

    always_comb
    begin
        next_state = state;
        next_bit_idx = bit_idx;
        next_tick_cnt = tick_cnt + 22'h1;
        next_shreg = shreg;
        next_lead_cnt = lead_cnt;
        next_echo_drop = echo_drop;
        case (state)
            RDGEC_IDLE:
            begin
                next_tick_cnt = 22'h0;
                if (fq.out_valid)
                begin
                    next_state = RDGEC_LEAD;
                    next_lead_cnt = 2'h0;
                    next_bit_idx = 4'h0;
                    next_echo_drop = echo_word[`RDGEC_ECHO_BIT] && two_wire && second_channel;
                end
            end
            RDGEC_LEAD:
            begin
                if (tick_done)
                begin
                    next_tick_cnt = 22'h0;
                    next_bit_idx = bit_idx + 4'h1;
                    if (bit_idx == 4'(`RDGEC_BITS_PER_CHAR - 1))
                    begin
                        next_bit_idx = 4'h0;
                        next_lead_cnt = lead_cnt + 2'h1;
                        if (lead_cnt == 2'(`RDGEC_LEAD_CHARS - 1))
                        begin
                            next_state = RDGEC_SEND;
                        end
                    end
                end
            end
            RDGEC_SEND:
            begin
                if (bit_idx == 4'h0 && tick_cnt == 22'h0)
                begin
                    next_shreg = fq.out_data;
                end
                if (tick_done)
                begin
                    next_tick_cnt = 22'h0;
                    next_bit_idx = bit_idx + 4'h1;
                    if (bit_idx >= 4'h1 && bit_idx <= 4'h8)
                    begin
                        next_shreg = {1'b1, shreg[7:1]};
                    end
                    if (bit_idx == 4'(`RDGEC_BITS_PER_CHAR - 1))
                    begin
                        next_bit_idx = 4'h0;
                        next_state = fq.out_valid ? RDGEC_SEND : RDGEC_HOLD;
                    end
                end
            end
            RDGEC_HOLD:
            begin
                // Slow rates keep the gate open for milliseconds; fast rates close next cycle.
                if (baud_sel != `RDGEC_RATE_50 && baud_sel != `RDGEC_RATE_300)
                begin
                    next_state = RDGEC_NEXT;
                end
                else if (tick_cnt == 22'(`RDGEC_SLOW_HOLD_CYC - 1))
                begin
                    next_state = RDGEC_NEXT;
                end
            end
            RDGEC_NEXT:
            begin
                next_tick_cnt = 22'h0;
                next_state = RDGEC_IDLE;
            end
            default:
            begin
                next_state = RDGEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= RDGEC_IDLE;
            bit_idx <= 4'h0;
            tick_cnt <= 22'h0;
            shreg <= 8'hFF;
            lead_cnt <= 2'h0;
            echo_drop <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bit_idx <= next_bit_idx;
            tick_cnt <= next_tick_cnt;
            shreg <= next_shreg;
            lead_cnt <= next_lead_cnt;
            echo_drop <= next_echo_drop;
        end
    end

    // ======================================================================
    // Echo setting word
    always_comb
    begin
        next_echo_word = echo_word;
        if (buf_wr && buf_addr == `RDGEC_ECHO_ADDR)
        begin
            next_echo_word = buf_wdata;
        end
    end

    // ======================================================================
    // Output registers
    logic active;
    logic next_pos, next_oe, next_rx_valid;
    assign active = (state == RDGEC_LEAD) || (state == RDGEC_SEND) || (state == RDGEC_HOLD);

    always_comb
    begin
        next_oe = active;
        next_pos = 1'b1;
        if (state == RDGEC_SEND)
        begin
            if (bit_idx == 4'h0)
            begin
                next_pos = 1'b0;
            end
            else if (bit_idx <= 4'h8)
            begin
                next_pos = shreg[0];
            end
        end
        // Own characters are only seen while the gate is open, so that window defines echo.
        next_rx_valid = rx_char_valid && !(active && echo_drop);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            echo_word <= `RDGEC_ECHO_RESET;
            buf_rdata <= 16'h0000;
            tx_pair_pos <= 1'b1;
            tx_pair_neg <= 1'b0;
            tx_pair_oe <= 1'b0;
            tx_busy <= 1'b0;
            tx_ready <= 1'b0;
            rx_out_valid <= 1'b0;
            rx_out_data <= 8'h00;
        end
        else
        begin
            echo_word <= next_echo_word;
            buf_rdata <= (buf_rd && buf_addr == `RDGEC_ECHO_ADDR) ? echo_word : 16'h0000;
            tx_pair_pos <= next_pos;
            tx_pair_neg <= ~next_pos;
            tx_pair_oe <= next_oe;
            tx_busy <= next_oe;
            tx_ready <= fq.in_ready;
            rx_out_valid <= next_rx_valid;
            rx_out_data <= rx_char;
        end
    end
endmodule
`default_nettype wire

// file: tb/rdgec_asserts.sv
// Port checks for the driver gate and echo control block.
`timescale 1ns/100ps
`default_nettype none
module rdgec_asserts
(
    // Watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic buf_rd,
    input wire logic [8:0] buf_addr,
    input wire logic [15:0] buf_rdata,
    input wire logic two_wire,
    input wire logic second_channel,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_out_valid,
    input wire logic [7:0] rx_out_data,
    input wire logic tx_pair_pos,
    input wire logic tx_pair_neg,
    input wire logic tx_pair_oe,
    input wire logic tx_busy
);
    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_busy_oe: assert property (tx_busy == tx_pair_oe)
        else $error("busy and enable differ");
    a_pair_diff: assert property (tx_pair_neg == !tx_pair_pos)
        else $error("pair not complementary");
    a_idle_mark: assert property (!tx_pair_oe |-> tx_pair_pos)
        else $error("line off mark while floating");
    a_lead_mark: assert property ($rose(tx_pair_oe) |-> tx_pair_pos [*8])
        else $error("data began without lead mark");
    a_map_only: assert property (buf_rd && buf_addr != 9'h1C2 |=> buf_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rd_quiet: assert property (!buf_rd |=> buf_rdata == 16'h0000)
        else $error("read data without read");
    a_echo_kept: assert property (rx_char_valid && !(two_wire && second_channel)
        |=> rx_out_valid && rx_out_data == $past(rx_char))
        else $error("char lost outside suppression");
    a_no_spont: assert property (rx_out_valid |-> $past(rx_char_valid))
        else $error("delivered char without input");
endmodule
bind rdgec_top rdgec_asserts i_rdgec_asserts (.clk, .reset, .buf_rd, .buf_addr, .buf_rdata,
    .two_wire, .second_channel, .rx_char_valid, .rx_char, .rx_out_valid, .rx_out_data,
    .tx_pair_pos, .tx_pair_neg, .tx_pair_oe, .tx_busy);
`default_nettype wire

// file: tb/rdgec_line_partner.sv
// Far-side serial device: decodes the pair and hears it on the receive pair.
`timescale 1ns/100ps
`default_nettype none
module rdgec_line_partner
#(
    parameter int BIT = 2604
)
(
    // Clock
    input wire logic clk,
    // Pair and injected characters
    input wire logic tx_pair_pos,
    input wire logic tx_pair_oe,
    input wire logic inj_valid,
    input wire logic [7:0] inj_data,
    // Receive pair and decoded line
    output logic rx_char_valid,
    output logic [7:0] rx_char,
    output var logic dec_valid,
    output var logic [7:0] dec_data,
    output var int dec_lead
);
    // ==================================================================
    // Decoder
    logic line;
    logic echo_v;
    logic [7:0] echo_d;
    int lead;
    // A floating pair reads as mark, as a biased line would.
    assign line = tx_pair_oe ? tx_pair_pos : 1'b1;
    assign rx_char_valid = echo_v | inj_valid;
    assign rx_char = echo_v ? echo_d : inj_data;
    initial
    begin
        lead = 0;
        echo_v = 1'b0;
        echo_d = 8'h00;
        dec_valid = 1'b0;
        dec_data = 8'h00;
        dec_lead = 0;
        forever
        begin
            @(negedge clk);
            echo_v <= 1'b0;
            dec_valid <= 1'b0;
            lead = tx_pair_oe ? lead + 1 : 0;
            // Nothing is taken off the line until a start bit leads a character.
            if (line == 1'b0)
            begin
                repeat (BIT / 2) @(negedge clk);
                for (int b = 0; b < 8; b++)
                begin
                    repeat (BIT) @(negedge clk);
                    echo_d[b] = line;
                end
                repeat (BIT) @(negedge clk);
                // A bad stop bit means noise, so the char is dropped.
                dec_valid <= line;
                echo_v <= line;
                dec_data <= echo_d;
                dec_lead <= lead;
                lead = 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the driver gate and echo control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ==================================================================
    // Signals and instances
    localparam int BIT = 50000000 / 19200;
    logic clk, reset, buf_wr, buf_rd, two_wire, tx_valid, tx_ready, inj_valid;
    logic rx_char_valid, rx_out_valid, tx_pair_pos, tx_pair_neg, tx_pair_oe, tx_busy;
    logic dec_valid, first, second_channel;
    logic [8:0] buf_addr;
    logic [15:0] buf_wdata, buf_rdata, w;
    logic [7:0] tx_data, inj_data, rx_char, rx_out_data, dec_data;
    int dec_lead, failures, cmp_count, cyc, last_dec, n, i;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    rdgec_top i_rdgec_top (.clk, .reset, .buf_wr, .buf_rd, .buf_addr, .buf_wdata, .buf_rdata,
        .baud_sel(3'h7), .two_wire, .second_channel, .tx_valid, .tx_data, .tx_ready,
        .rx_char_valid, .rx_char, .rx_out_valid, .rx_out_data, .tx_pair_pos, .tx_pair_neg,
        .tx_pair_oe, .tx_busy);
    rdgec_line_partner #(.BIT(BIT)) i_rdgec_line_partner (.clk, .tx_pair_pos, .tx_pair_oe,
        .inj_valid, .inj_data, .rx_char_valid, .rx_char, .dec_valid, .dec_data, .dec_lead);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==================================================================
    // Tasks
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [8:0] a, input logic [15:0] d);
        @(negedge clk);
        buf_wr = wr;
        buf_rd = !wr;
        buf_addr = a;
        buf_wdata = d;
        @(negedge clk);
        buf_wr = 1'b0;
        buf_rd = 1'b0;
    endtask
    task automatic inject(input logic [7:0] d);
        @(negedge clk);
        inj_valid = 1'b1;
        inj_data = d;
        @(negedge clk);
        inj_valid = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, input logic echo);
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data = d;
        @(negedge clk);
        tx_valid = 1'b0;
        txq.push_back(d);
        if (echo)
            rxq.push_back(d);
    endtask
    task automatic pulse_reset();
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        txq.delete();
        rxq.delete();
        @(negedge clk);
        chk("oe_after_reset", 0, tx_pair_oe);
        chk("pos_after_reset", 1, tx_pair_pos);
        chk("busy_after_reset", 0, tx_busy);
    endtask
    task automatic wait_oe(input logic lvl, input int lim);
        n = 0;
        while (tx_pair_oe !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= lim)
        begin
            failures++;
            report_and_stop();
        end
    endtask
    // ==================================================================
    // Output watcher
    always @(posedge clk)
    begin
        #1;
        cyc++;
        if (rx_out_valid === 1'b1)
        begin
            chk("rx_expected", 1, rxq.size() > 0);
            if (rxq.size() > 0)
                chk("rx_out_data", rxq.pop_front(), rx_out_data);
        end
        if (dec_valid === 1'b1)
        begin
            last_dec = cyc;
            chk("tx_expected", 1, txq.size() > 0);
            if (txq.size() > 0)
                chk("line_char", txq.pop_front(), dec_data);
            if (first)
                chk("lead_mark", 1, dec_lead >= 20 * BIT - 2);
            first = 1'b0;
        end
        if (tx_pair_oe !== 1'b1)
            first = 1'b1;
    end
    // ==================================================================
    // Main sequence
    initial
    begin
        {reset, two_wire, second_channel} = 3'b111;
        {buf_wr, buf_rd, tx_valid, inj_valid} = 4'h0;
        {buf_addr, buf_wdata, tx_data, inj_data} = '0;
        {failures, cmp_count, cyc, last_dec} = '0;
        first = 1'b1;
        w = 16'($urandom(82));
        repeat (10) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        bus(0, 9'h1C2, 0);
        chk("echo_reset", 16'h0000, buf_rdata);
        w = 16'($urandom());
        bus(1, 9'h1C2, w);
        bus(1, 9'h1C3, ~w);
        bus(0, 9'h1C3, 0);
        chk("unmapped", 16'h0000, buf_rdata);
        bus(0, 9'h1C2, 0);
        chk("echo_word", w, buf_rdata);
        $display("test registers done");
        bus(1, 9'h1C2, 16'h0001);
        rxq.push_back(w[7:0]);
        inject(w[7:0]);
        send(w[15:8], 1'b0);
        wait_oe(1'b1, 100);
        repeat (500) @(negedge clk);
        inject(~w[7:0]);
        repeat (5) @(negedge clk);
        chk("rx_dropped", 0, rxq.size());
        // A reset in mid-lead aborts the send; the echo word must be back to zero.
        pulse_reset();
        bus(0, 9'h1C2, 0);
        chk("echo_after_reset", 16'h0000, buf_rdata);
        $display("test suppress done");
        send(w[15:8], 1'b1);
        wait_oe(1'b1, 100);
        repeat (500) @(negedge clk);
        bus(1, 9'h1C2, 16'h0001);
        wait_oe(1'b0, 100000);
        chk("close_time", 1, cyc - last_dec < BIT + BIT / 2 + 4);
        chk("tx_sent", 0, txq.size());
        chk("rx_echoed", 0, rxq.size());
        $display("test echo kept done");
        // Mode is changed only between sends, so it is latched with the echo bit.
        for (i = 0; i < 2; i++)
        begin
            {two_wire, second_channel} = (i == 0) ? 2'b10 : 2'b01;
            bus(1, 9'h1C2, 16'h0001);
            send(w[7:0], 1'b0);
            wait_oe(1'b1, 100);
            repeat (500) @(negedge clk);
            rxq.push_back(~w[15:8]);
            inject(~w[15:8]);
            repeat (5) @(negedge clk);
            chk("rx_mode_kept", 0, rxq.size());
            pulse_reset();
        end
        {two_wire, second_channel} = 2'b11;
        $display("test mode done");
        i = 0;
        while (i < 12 && tx_ready === 1'b1)
        begin
            w = 16'($urandom());
            send(w[7:0], 1'b1);
            i++;
            @(negedge clk);
        end
        chk("fill_count", 1, i >= 8 && i <= 9);
        chk("oe_held", 1, tx_pair_oe);
        // Draining eight characters would cost far too many cycles, so reset flushes them.
        pulse_reset();
        chk("ready_after_flush", 1, tx_ready);
        chk("rx_left", 0, rxq.size());
        $display("test fill done");
        report_and_stop();
    end
endmodule
`default_nettype wire
